// File: design/tdc_pkg.sv
package tdc_pkg;
    localparam int NUM_CH = 3;
    localparam int SIZE_W = 16;
    localparam int DATA_W = 16;
    localparam int TSEL_W = 4;
    localparam int NUM_SLOT = 16;

    // Trigger select codes handled by dedicated sources
    localparam logic [3:0] TSEL_CONV = 4'h6;
    localparam logic [3:0] TSEL_I2C_RX = 4'hc;
    localparam logic [3:0] TSEL_I2C_TX = 4'hd;
    localparam logic [3:0] TSEL_CHAIN = 4'he;
    localparam logic [3:0] TSEL_EXT = 4'hf;

    localparam logic [1:0] MODE_SINGLE = 2'h0;
    localparam logic [1:0] MODE_BLOCK = 2'h1;
    localparam logic [1:0] MODE_BURST = 2'h2;

    // Timing
    localparam int CLK_MHZ = 250;
    localparam int OSC_START_NS = 6000;
    localparam int OSC_START_CYC = (OSC_START_NS * CLK_MHZ) / 1000;
    localparam logic [1:0] SYNC_ACTIVE_CYC = 2'h1;
    localparam logic [1:0] SYNC_SLEEP_CYC = 2'h2;

    // Vector word codes
    localparam logic [15:0] VEC_NONE = 16'h0000;
    localparam logic [15:0] VEC_CH0 = 16'h0002;
    localparam logic [15:0] VEC_CH1 = 16'h0004;
    localparam logic [15:0] VEC_CH2 = 16'h0006;

    localparam logic [2:0] FLAGS_RESET = 3'h0;
    localparam logic [1:0] TOP_RESET = 2'h0;

    typedef struct packed {
        logic enable;
        logic irq_enable;
        logic [1:0] mode;
        logic [3:0] tsel;
        logic [15:0] size;
    } tdc_chan_cfg_type;

    typedef struct packed {
        logic [1:0] chan;
        logic [15:0] data;
    } tdc_word_type;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_WAKE = 3'b001,
        ST_SYNC = 3'b010,
        ST_READ = 3'b011,
        ST_WRITE = 3'b100,
        ST_GAP = 3'b101
    } tdc_state_type;
endpackage

// File: design/tdc_buf.sv
`timescale 1ns/1ps
module tdc_buf #(
    parameter int WIDTH = 18
) (
    input wire logic sys_clk_i, // System clock
    input wire logic rst_i, // Synchronous reset
    input wire logic in_valid_i, // Push request
    output logic in_ready_o, // Space available
    input wire logic [WIDTH-1:0] in_data_i, // Pushed word
    output logic out_valid_o, // Head word valid
    input wire logic out_ready_i, // Consumer takes head
    output logic [WIDTH-1:0] out_data_o // Head word, registered
);
    logic [WIDTH-1:0] head_q, head_d, tail_q, tail_d;
    logic [1:0] cnt_q, cnt_d;

    always_comb begin
        logic push;
        logic pop;
        push = 1'b0;
        pop = 1'b0;
        push = in_valid_i && (cnt_q != 2'h2);
        pop = out_ready_i && (cnt_q != 2'h0);
        head_d = head_q;
        tail_d = tail_q;
        cnt_d = cnt_q;
        if (pop) begin
            head_d = tail_q;
        end
        if (push) begin
            if (cnt_q == 2'h0 || (cnt_q == 2'h1 && pop)) begin
                head_d = in_data_i;
            end else begin
                tail_d = in_data_i;
            end
        end
        cnt_d = 2'(cnt_q + {1'b0, push} - {1'b0, pop});
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            cnt_q <= 2'h0;
            head_q <= '0;
            tail_q <= '0;
        end else begin
            cnt_q <= cnt_d;
            head_q <= head_d;
            tail_q <= tail_d;
        end
    end

    assign in_ready_o = (cnt_q != 2'h2);
    assign out_valid_o = (cnt_q != 2'h0);
    assign out_data_o = head_q;
endmodule

// File: design/tdc_top.sv
`timescale 1ns/1ps
// Behaviour
// - Enabled NMI aborts any transfer in progress
// - Clearing enable stops a running burst-block
// - Default fixed priority: channel 0, 1, 2
// - Running transfer never preempted by higher channel
// - Rotating: finished channel becomes lowest priority
// - Rotating off restores default fixed order
// - One or two sync cycles per transfer
// - Each move two cycles plus one wait
// - Transfer while CPU sleeps, CPU stays halted
// - Restart stopped clock for transfer, then stop
// - Single transfer within 4/5 cycles, +6us wake
// - Maskable interrupts held off during transfer
// - Transfer takes bus mid-ISR, suspending CPU
// - Done flag set when size count hits zero
// - Interrupt needs flag, channel and global enable
// - Done flags cleared only by software/vector access
// - Vector reports highest enabled pending flag, 2/4/6
// - Vector access clears only highest enabled pending flag
// - I2C flags trigger, acked, gated by enables
// - Conversion flag triggers per sequence mode
// - Reading a result slot clears its flag
// - Code 1110 chains done flags, no clear
// - Code 1111 triggers from external pin
module tdc_top (
    input wire logic sys_clk_i, // System clock, 250 MHz
    input wire logic rst_i, // Synchronous reset, active high
    input tdc_pkg::tdc_chan_cfg_type [2:0] cfg_i, // Per-channel configuration
    input wire logic rotating_priority_enable_i, // Rotating priority
    input wire logic nmi_abort_enable_i, // NMI may abort transfers
    input wire logic global_irq_enable_i, // CPU global interrupt enable
    input wire logic nmi_i, // Non-maskable interrupt request
    input wire logic mclk_running_i, // Main clock currently running
    input wire logic cpu_off_i, // CPU halted in low-power mode
    input wire logic [15:0] periph_trig_i, // Other trigger flags by code
    input wire logic i2c_rx_flag_i, // I2C receive flag
    input wire logic i2c_tx_flag_i, // I2C transmit flag
    input wire logic i2c_rx_irq_enable_i, // I2C receive irq enable
    input wire logic i2c_tx_irq_enable_i, // I2C transmit irq enable
    input wire logic [15:0] conv_done_flag_i, // Conversion done flags
    input wire logic [1:0] conv_sequence_mode_i, // Conversion sequence mode
    input wire logic [3:0] conv_slot_used_i, // Slot of single conversion
    input wire logic [3:0] conv_last_slot_i, // Last slot of sequence
    input wire logic external_trigger_pin_i, // External trigger
    input wire logic [2:0] flag_clear_i, // Software clear of done flags
    input wire logic vector_access_i, // Vector word read or write
    input wire logic [15:0] rd_data_i, // Read data, cycle after strobe
    input wire logic wr_ready_i, // Write side accepts word
    output logic rd_strobe_o, // Source read strobe
    output logic [1:0] rd_chan_o, // Channel of read
    output logic wr_valid_o, // Write word valid
    output logic [1:0] wr_chan_o, // Channel of write word
    output logic [15:0] wr_data_o, // Write data
    output logic cpu_hold_o, // CPU suspended, maskable ints held
    output logic mclk_wake_o, // Restart main clock from oscillator
    output logic i2c_rx_ack_o, // Clears I2C receive flag
    output logic i2c_tx_ack_o, // Clears I2C transmit flag
    output logic [15:0] conv_clear_o, // Clears conversion flags
    output logic [2:0] channel_done_flag_o, // Done flags
    output logic irq_o, // Controller interrupt request
    output logic [15:0] irq_vector_word_o // Vector word
);
    import tdc_pkg::*;

    function automatic logic [1:0] next_ch(input logic [1:0] c);
        return (c == 2'h2) ? 2'h0 : 2'(c + 2'h1);
    endfunction

    function automatic logic [1:0] pick(input logic [2:0] req, input logic [1:0] top);
        logic [1:0] c;
        logic [1:0] r;
        c = top;
        r = 2'h3;
        for (int i = 0; i < NUM_CH; i++) begin
            if (r == 2'h3 && req[c]) begin
                r = c;
            end
            c = next_ch(c);
        end
        return r;
    endfunction

    function automatic logic [15:0] vec_of(input logic [2:0] act);
        if (act[0]) begin
            return VEC_CH0;
        end else if (act[1]) begin
            return VEC_CH1;
        end else if (act[2]) begin
            return VEC_CH2;
        end
        return VEC_NONE;
    endfunction

    function automatic logic [3:0] conv_slot(input logic [1:0] mode, input logic [3:0] used,
        input logic [3:0] last);
        return mode[0] ? last : used;
    endfunction

    // Trigger capture group
    logic [2:0] src;
    logic [2:0] src_prev_q, src_prev_d;
    logic [2:0] pend_q, pend_d;
    logic [2:0] en_prev_q, en_prev_d;

    // Transfer group
    tdc_state_type state_q, state_d;
    logic [1:0] ch_q, ch_d;
    logic [1:0] sync_q, sync_d;
    logic [10:0] wake_q, wake_d;
    logic [1:0] top_q, top_d;
    logic [SIZE_W-1:0] cnt_q [NUM_CH];
    logic [SIZE_W-1:0] cnt_d [NUM_CH];
    logic rd_q, rd_d, hold_q, hold_d, wake_o_q, wake_o_d;
    logic rx_ack_q, rx_ack_d, tx_ack_q, tx_ack_d;
    logic [15:0] conv_clr_q, conv_clr_d;
    logic [2:0] done_set;
    // Block end remembered from the write cycle into the wait cycle
    logic done_set_q;
    logic [1:0] sel;
    logic abort;

    // Flag group
    logic [2:0] flags_q, flags_d;
    logic irq_q, irq_d;
    logic [15:0] vec_q, vec_d;

    logic buf_in_ready, buf_out_valid;
    tdc_word_type buf_in, buf_out;

    always_comb begin
        logic [3:0] slot;
        slot = 4'h0;
        slot = conv_slot(conv_sequence_mode_i, conv_slot_used_i, conv_last_slot_i);
        for (int i = 0; i < NUM_CH; i++) begin
            unique case (cfg_i[i].tsel)
                TSEL_CONV: src[i] = conv_done_flag_i[slot];
                TSEL_I2C_RX: src[i] = i2c_rx_flag_i && !i2c_rx_irq_enable_i;
                TSEL_I2C_TX: src[i] = i2c_tx_flag_i && !i2c_tx_irq_enable_i;
                TSEL_CHAIN: src[i] = flags_q[(i == 0) ? 2 : i - 1];
                TSEL_EXT: src[i] = external_trigger_pin_i;
                default: src[i] = periph_trig_i[cfg_i[i].tsel];
            endcase
        end
    end

    always_comb begin
        src_prev_d = src;
        en_prev_d = {cfg_i[2].enable, cfg_i[1].enable, cfg_i[0].enable};
        pend_d = pend_q;
        if (state_q == ST_IDLE && sel != 2'h3) begin
            pend_d[sel] = 1'b0;
        end
        for (int i = 0; i < NUM_CH; i++) begin
            if (!cfg_i[i].enable) begin
                pend_d[i] = 1'b0;
            end else if (src[i] && !src_prev_q[i]) begin
                pend_d[i] = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            src_prev_q <= 3'h0;
            en_prev_q <= 3'h0;
            pend_q <= 3'h0;
        end else begin
            src_prev_q <= src_prev_d;
            en_prev_q <= en_prev_d;
            pend_q <= pend_d;
        end
    end

    // Arbitration only in idle, so a running transfer is never preempted
    assign sel = pick(pend_q, top_q);
    assign abort = (nmi_i && nmi_abort_enable_i)
        || (cfg_i[ch_q].mode == MODE_BURST && !cfg_i[ch_q].enable);

    always_comb begin
        state_d = state_q;
        ch_d = ch_q;
        sync_d = sync_q;
        wake_d = wake_q;
        top_d = rotating_priority_enable_i ? top_q : TOP_RESET;
        cnt_d = cnt_q;
        done_set = 3'h0;
        rx_ack_d = 1'b0;
        tx_ack_d = 1'b0;
        conv_clr_d = 16'h0000;
        wake_o_d = wake_o_q;
        for (int i = 0; i < NUM_CH; i++) begin
            if (cfg_i[i].enable && !en_prev_q[i]) begin
                cnt_d[i] = cfg_i[i].size;
            end
        end
        unique case (state_q)
            ST_IDLE: begin
                wake_o_d = 1'b0;
                if (sel != 2'h3) begin
                    ch_d = sel;
                    rx_ack_d = (cfg_i[sel].tsel == TSEL_I2C_RX);
                    tx_ack_d = (cfg_i[sel].tsel == TSEL_I2C_TX);
                    sync_d = cpu_off_i ? SYNC_SLEEP_CYC : SYNC_ACTIVE_CYC;
                    if (!mclk_running_i) begin
                        wake_o_d = 1'b1;
                        wake_d = 11'(OSC_START_CYC - 1);
                        state_d = ST_WAKE;
                    end else begin
                        state_d = ST_SYNC;
                    end
                end
            end
            ST_WAKE: begin
                wake_d = 11'(wake_q - 11'h1);
                if (wake_q == 11'h0) begin
                    state_d = ST_SYNC;
                end
            end
            ST_SYNC: begin
                sync_d = 2'(sync_q - 2'h1);
                if (sync_q == 2'h1 && buf_in_ready) begin
                    state_d = ST_READ;
                end
            end
            ST_READ: begin
                state_d = ST_WRITE;
            end
            ST_WRITE: begin
                cnt_d[ch_q] = SIZE_W'(cnt_q[ch_q] - 1'b1);
                if (cnt_q[ch_q] == SIZE_W'(1)) begin
                    done_set[ch_q] = 1'b1;
                    cnt_d[ch_q] = cfg_i[ch_q].size;
                end
                if (cfg_i[ch_q].tsel == TSEL_CONV) begin
                    conv_clr_d = 16'h0001 << conv_slot(conv_sequence_mode_i,
                        conv_slot_used_i, conv_last_slot_i);
                end
                state_d = ST_GAP;
            end
            ST_GAP: begin
                if (cfg_i[ch_q].mode != MODE_SINGLE && !done_set_q && buf_in_ready) begin
                    state_d = ST_READ;
                end else if (cfg_i[ch_q].mode == MODE_SINGLE || done_set_q) begin
                    if (rotating_priority_enable_i) begin
                        top_d = next_ch(ch_q);
                    end
                    state_d = ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
        if (abort && state_q != ST_IDLE) begin
            state_d = ST_IDLE;
        end
        rd_d = (state_d == ST_READ);
        hold_d = (state_d != ST_IDLE);
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            state_q <= ST_IDLE;
            ch_q <= 2'h0;
            sync_q <= 2'h0;
            wake_q <= 11'h000;
            top_q <= TOP_RESET;
            for (int i = 0; i < NUM_CH; i++) begin
                cnt_q[i] <= '0;
            end
            rd_q <= 1'b0;
            hold_q <= 1'b0;
            wake_o_q <= 1'b0;
            rx_ack_q <= 1'b0;
            tx_ack_q <= 1'b0;
            conv_clr_q <= 16'h0000;
            done_set_q <= 1'b0;
        end else begin
            state_q <= state_d;
            ch_q <= ch_d;
            sync_q <= sync_d;
            wake_q <= wake_d;
            top_q <= top_d;
            cnt_q <= cnt_d;
            rd_q <= rd_d;
            hold_q <= hold_d;
            wake_o_q <= wake_o_d;
            rx_ack_q <= rx_ack_d;
            tx_ack_q <= tx_ack_d;
            conv_clr_q <= conv_clr_d;
            done_set_q <= |done_set;
        end
    end

    // Set beats any clear arriving in the same cycle
    always_comb begin
        logic [2:0] act;
        act = 3'h0;
        act = flags_q & {cfg_i[2].irq_enable, cfg_i[1].irq_enable, cfg_i[0].irq_enable};
        flags_d = flags_q & ~flag_clear_i;
        if (vector_access_i) begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (vec_of(act) == vec_of(3'(1 << i))) begin
                    flags_d[i] = 1'b0;
                end
            end
        end
        flags_d = flags_d | done_set;
        act = flags_d & {cfg_i[2].irq_enable, cfg_i[1].irq_enable, cfg_i[0].irq_enable};
        vec_d = vec_of(act);
        irq_d = global_irq_enable_i && (act != 3'h0);
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            flags_q <= FLAGS_RESET;
            irq_q <= 1'b0;
            vec_q <= VEC_NONE;
        end else begin
            flags_q <= flags_d;
            irq_q <= irq_d;
            vec_q <= vec_d;
        end
    end

    assign buf_in = '{chan: ch_q, data: rd_data_i};

    // Two words of slack so a stalled writer loses nothing
    tdc_buf #(
        .WIDTH($bits(tdc_word_type))
    ) u_buf (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .in_valid_i(state_q == ST_WRITE),
        .in_ready_o(buf_in_ready),
        .in_data_i(buf_in),
        .out_valid_o(buf_out_valid),
        .out_ready_i(wr_ready_i),
        .out_data_o(buf_out)
    );

    assign rd_strobe_o = rd_q;
    assign rd_chan_o = ch_q;
    assign wr_valid_o = buf_out_valid;
    assign wr_chan_o = buf_out.chan;
    assign wr_data_o = buf_out.data;
    assign cpu_hold_o = hold_q;
    assign mclk_wake_o = wake_o_q;
    assign i2c_rx_ack_o = rx_ack_q;
    assign i2c_tx_ack_o = tx_ack_q;
    assign conv_clear_o = conv_clr_q;
    assign channel_done_flag_o = flags_q;
    assign irq_o = irq_q;
    assign irq_vector_word_o = vec_q;
endmodule

// File: testbench/tdc_top_asserts.sv
`timescale 1ns/1ps
module tdc_chk
    import tdc_pkg::*;
(
    input wire logic sys_clk_i, // Clock
    input wire logic rst_i, // Reset
    input tdc_pkg::tdc_chan_cfg_type [2:0] cfg_i, // Config
    input wire logic global_irq_enable_i, // Global enable
    input wire logic mclk_running_i, // Clock on
    input wire logic [2:0] flag_clear_i, // Flag clears
    input wire logic vector_access_i, // Vector access
    input wire logic [15:0] rd_data_i, // Read data
    input wire logic rd_strobe_o, // Read strobe
    input wire logic cpu_hold_o, // Bus held
    input wire logic mclk_wake_o, // Clock wake
    input wire logic wr_valid_o, // Word valid
    input wire logic [15:0] wr_data_o, // Word data
    input wire logic [2:0] channel_done_flag_o, // Done flags
    input wire logic irq_o, // Interrupt
    input wire logic [15:0] irq_vector_word_o // Vector
);
    logic [2:0] pend;
    logic [15:0] expv;
    logic [2:0] ien_q;
    logic gie_q;
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);
    // Flags and vector update on the same edge, enables seen one edge earlier
    always_ff @(posedge sys_clk_i) begin
        ien_q <= {cfg_i[2].irq_enable, cfg_i[1].irq_enable, cfg_i[0].irq_enable};
        gie_q <= global_irq_enable_i;
    end
    assign pend = channel_done_flag_o & ien_q;
    assign expv = pend[0] ? VEC_CH0 : pend[1] ? VEC_CH1 : pend[2] ? VEC_CH2 : VEC_NONE;
    property p_vec;
        irq_vector_word_o == expv;
    endproperty
    a_vec: assert property (p_vec) else $error("vector word wrong");
    property p_irq;
        irq_o == (gie_q && (|pend));
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt request wrong");
    // A flag may only drop for a software clear or a vector access
    property p_clr;
        |($past(channel_done_flag_o) & ~channel_done_flag_o & ~$past(flag_clear_i))
            |-> $past(vector_access_i);
    endproperty
    a_clr: assert property (p_clr) else $error("done flag dropped");
    property p_hold;
        rd_strobe_o |-> cpu_hold_o;
    endproperty
    a_hold: assert property (p_hold) else $error("read without bus");
    property p_gap;
        rd_strobe_o |=> !rd_strobe_o [*2];
    endproperty
    a_gap: assert property (p_gap) else $error("move too short");
    property p_sync;
        $rose(cpu_hold_o) && mclk_running_i && !wr_valid_o |-> ##[1:2] rd_strobe_o;
    endproperty
    a_sync: assert property (p_sync) else $error("sync too long");
    property p_data;
        $rose(wr_valid_o) |-> wr_data_o == $past(rd_data_i);
    endproperty
    a_data: assert property (p_data) else $error("word data wrong");
    property p_wake;
        $fell(mclk_wake_o) |-> !cpu_hold_o;
    endproperty
    a_wake: assert property (p_wake) else $error("clock dropped early");
endmodule
bind tdc_top tdc_chk u_chk (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .cfg_i(cfg_i),
    .global_irq_enable_i(global_irq_enable_i), .mclk_running_i(mclk_running_i),
    .flag_clear_i(flag_clear_i), .vector_access_i(vector_access_i), .rd_data_i(rd_data_i),
    .rd_strobe_o(rd_strobe_o), .cpu_hold_o(cpu_hold_o), .mclk_wake_o(mclk_wake_o),
    .wr_valid_o(wr_valid_o), .wr_data_o(wr_data_o), .channel_done_flag_o(channel_done_flag_o),
    .irq_o(irq_o), .irq_vector_word_o(irq_vector_word_o)
);

// File: testbench/tdc_mem_model.sv
`timescale 1ns/1ps
module tdc_mem_model (
    input wire logic sys_clk_i, // Clock
    input wire logic rd_strobe_i, // Read strobe
    input wire logic [1:0] rd_chan_i, // Read channel
    input wire logic stall_i, // Refuse writes
    output logic [15:0] rd_data_o, // Read data
    output logic wr_ready_o // Write accept
);
    logic [11:0] cnt_q = 12'h001;
    logic [15:0] dat_q = 16'h0f0f;
    assign wr_ready_o = !stall_i;
    assign rd_data_o = dat_q;
    // Data holds one cycle only; toggling exposes late sampling
    always @(posedge sys_clk_i) begin
        if (rd_strobe_i) begin
            dat_q <= {rd_chan_i, 2'b00, cnt_q};
            cnt_q <= cnt_q + 12'h001;
        end else begin
            dat_q <= ~dat_q;
        end
    end
endmodule

// File: testbench/tb_tdc_top.sv
`timescale 1ns/1ps
module tb_tdc_top;
    import tdc_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    tdc_chan_cfg_type [2:0] cfg;
    logic rot = 1'b0, nmia = 1'b0, global_irq_enable = 1'b0, nmi = 1'b0, mrun = 1'b1, coff = 1'b0;
    logic i2r = 1'b0, i2t = 1'b0, ext = 1'b0, va = 1'b0, stall = 1'b0;
    logic [15:0] ptrig = 16'h0000, conv = 16'h0000, cseen = 16'h0000;
    logic [1:0] i2e = 2'h0, cmode = 2'h0, rch, wch;
    logic [2:0] fclr = 3'h0, acc = 3'h0, flags;
    logic wrdy, strb, wval, hold, wake, rack, tack, irq;
    logic [15:0] rdat, wdat, cclr, vec;
    logic [17:0] wq[$];
    logic [11:0] lo = 12'h000;
    int hl, hmax, fails, samples_checked;
    int cm[6] = '{0, 2, 1, 1, 3, 3};
    int cb[6] = '{3, 3, 2, 5, 2, 5};
    always #2 clk = ~clk;
    tdc_top uut (
        .sys_clk_i(clk), .rst_i(rst), .cfg_i(cfg), .rotating_priority_enable_i(rot),
        .nmi_abort_enable_i(nmia), .global_irq_enable_i(global_irq_enable), .nmi_i(nmi),
        .mclk_running_i(mrun), .cpu_off_i(coff), .periph_trig_i(ptrig),
        .i2c_rx_flag_i(i2r), .i2c_tx_flag_i(i2t), .i2c_rx_irq_enable_i(i2e[1]),
        .i2c_tx_irq_enable_i(i2e[0]), .conv_done_flag_i(conv), .conv_sequence_mode_i(cmode),
        .conv_slot_used_i(4'h3), .conv_last_slot_i(4'h5), .external_trigger_pin_i(ext),
        .flag_clear_i(fclr), .vector_access_i(va), .rd_data_i(rdat), .wr_ready_i(wrdy),
        .rd_strobe_o(strb), .rd_chan_o(rch), .wr_valid_o(wval), .wr_chan_o(wch),
        .wr_data_o(wdat), .cpu_hold_o(hold), .mclk_wake_o(wake), .i2c_rx_ack_o(rack),
        .i2c_tx_ack_o(tack), .conv_clear_o(cclr), .channel_done_flag_o(flags),
        .irq_o(irq), .irq_vector_word_o(vec)
    );
    tdc_mem_model u_mem (
        .sys_clk_i(clk), .rd_strobe_i(strb), .rd_chan_i(rch), .stall_i(stall),
        .rd_data_o(rdat), .wr_ready_o(wrdy)
    );
    always @(posedge clk) begin
        if (wval && wrdy) begin
            wq.push_back({wch, wdat});
        end
        acc <= acc | {wake, rack, tack};
        cseen <= cseen | cclr;
        hl <= hold ? hl + 1 : 0;
        if (hl > hmax) begin
            hmax <= hl;
        end
    end
    task finish_test;
        $display("fails=%0d samples_checked=%0d", fails, samples_checked);
        if (fails == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task chk(input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: exp %h got %h", $time, exp, got);
        end
    endtask
    // Quiet means no bus hold and an empty buffer for six cycles
    task settle;
        int q;
        q = 0;
        for (int k = 0; k < 5000 && q < 6; k++) begin
            cyc(1);
            q = (hold || wval) ? 0 : q + 1;
        end
        chk(16'h0006, 16'(q));
    endtask
    task go(input logic [2:0] m);
        for (int i = 0; i < 3; i++) begin
            cfg[i].enable = 1'b0;
        end
        cyc(1);
        for (int i = 0; i < 3; i++) begin
            cfg[i].enable = m[i];
        end
        cyc(2);
    endtask
    task fire(input logic [15:0] b);
        ptrig = b;
        cyc(1);
        ptrig = 16'h0000;
        settle;
    endtask
    task pva;
        va = 1'b1;
        cyc(1);
        va = 1'b0;
        cyc(2);
    endtask
    task clr;
        fclr = 3'h7;
        cyc(1);
        fclr = 3'h0;
        cyc(2);
    endtask
    task words(input int n, input logic [11:0] ch);
        logic [17:0] w;
        chk(16'(n), 16'(wq.size()));
        for (int i = 0; i < n && wq.size() > 0; i++) begin
            w = wq.pop_front();
            chk({10'h0, ch[2*i+:2], ch[2*i+:2], 2'b00}, {10'h0, w[17:12]});
            chk(16'h1, {15'h0, w[11:0] > lo});
            lo = w[11:0];
        end
        wq.delete();
    endtask
    task abort(input logic by_nmi);
        clr;
        go(3'h7);
        fire(16'h0000);
        ptrig = 16'h0008;
        cyc(7);
        nmi = by_nmi;
        cfg[2].enable = by_nmi;
        cyc(1);
        nmi = 1'b0;
        ptrig = 16'h0000;
        settle;
        chk(16'h0, {15'h0, flags[2]});
        chk(16'h1, {15'h0, wq.size() < 8});
        wq.delete();
    endtask
    initial begin
        for (int i = 0; i < 3; i++) begin
            cfg[i] = '{1'b0, 1'b1, MODE_SINGLE, 4'(i + 1), 16'h0001};
        end
        cyc(16);
        rst = 1'b0;
        go(3'h7);
        fire(16'h000e);
        words(3, 12'h024);
        chk(16'h7, {13'h0, flags});
        cfg[0].irq_enable = 1'b0;
        cyc(2);
        chk(VEC_CH1, vec);
        chk(16'h0, {15'h0, irq});
        cfg[0].irq_enable = 1'b1;
        global_irq_enable = 1'b1;
        cyc(2);
        chk(VEC_CH0, vec);
        chk(16'h1, {15'h0, irq});
        pva;
        chk(16'h6, {13'h0, flags});
        chk(VEC_CH1, vec);
        clr;
        chk(16'h0, {13'h0, flags});
        rot = 1'b1;
        fire(16'h0004);
        words(1, 12'h001);
        fire(16'h000e);
        words(3, 12'h012);
        rot = 1'b0;
        fire(16'h000e);
        words(3, 12'h024);
        cfg[2].mode = MODE_BLOCK;
        cfg[2].size = 16'h0004;
        go(3'h7);
        stall = 1'b1;
        ptrig = 16'h0008;
        cyc(4);
        ptrig = 16'h000a;
        cyc(30);
        ptrig = 16'h0000;
        chk(16'h3, {14'h0, wval, hold});
        stall = 1'b0;
        settle;
        words(5, 12'h0aa);
        cfg[2].size = 16'h0008;
        nmia = 1'b1;
        abort(1'b1);
        cfg[2].mode = MODE_BURST;
        abort(1'b0);
        cfg[2].mode = MODE_SINGLE;
        go(3'h1);
        for (int k = 0; k < 3; k++) begin
            coff = (k > 0);
            mrun = (k < 2);
            hmax = 0;
            acc = 3'h0;
            fire(16'h0002);
            chk(16'h1, {15'h0, hmax <= 4 + (k > 0) + (k == 2 ? OSC_START_CYC : 0)});
            chk(16'(k == 2 ? 4 : 0), {13'h0, acc});
            chk(16'h0, {15'h0, wake});
            words(1, 12'h000);
        end
        mrun = 1'b1;
        coff = 1'b0;
        for (int j = 0; j < 4; j++) begin
            cfg[0].tsel = j[1] ? TSEL_I2C_TX : TSEL_I2C_RX;
            i2e = {2{j[0]}};
            go(3'h1);
            acc = 3'h0;
            i2r = !j[1];
            i2t = j[1];
            settle;
            i2r = 1'b0;
            i2t = 1'b0;
            chk(16'(j[0] ? 0 : (j[1] ? 1 : 2)), {13'h0, acc});
            words(j[0] ? 0 : 1, 12'h000);
        end
        cfg[0].tsel = TSEL_CONV;
        for (int j = 0; j < 6; j++) begin
            cmode = 2'(cm[j]);
            go(3'h1);
            cseen = 16'h0000;
            conv = 16'h0001 << cb[j];
            settle;
            conv = 16'h0000;
            words(cb[j] != 2 ? 1 : 0, 12'h000);
            chk((cb[j] != 2) ? (16'h0001 << cb[j]) : 16'h0000, cseen);
        end
        cfg[0].tsel = 4'h1;
        cfg[1].tsel = TSEL_CHAIN;
        clr;
        go(3'h3);
        fire(16'h0002);
        words(2, 12'h004);
        chk(16'h3, {13'h0, flags});
        cfg[0].tsel = TSEL_EXT;
        go(3'h1);
        ext = 1'b1;
        settle;
        ext = 1'b0;
        words(1, 12'h000);
        finish_test;
    end
    initial begin
        repeat (60000) @(posedge clk);
        fails++;
        finish_test;
    end
endmodule
